// ==== logic/mfpr_params.svh ====
// constants for the multifunction pin routing block: offsets, fields, resets
// assumes inclusion by bare name from package and modules
`ifndef MFPR_PARAMS_SVH
`define MFPR_PARAMS_SVH

// register indices; byte address is four times the index
`define MFPR_GPO_IDX        8'h8B
`define MFPR_ROUTE_IDX      8'h8C

// reset values
`define MFPR_GPO_RST        8'h00
`define MFPR_ROUTE_RST      32'h0000_1000

// writable bits
`define MFPR_GPO_WMASK      8'h1F
`define MFPR_ROUTE_WMASK    32'h0FFF_FFFF

// select field positions and width
`define MFPR_SEL_W          4
`define MFPR_TERM6_LSB      24
`define MFPR_TERM5_LSB      20
`define MFPR_TERM4_LSB      16
`define MFPR_TERM3_LSB      12
`define MFPR_TERM2_LSB      8
`define MFPR_TERM1_LSB      4
`define MFPR_TERM0_LSB      0

// codes of interest
`define MFPR_CODE_GPI       4'h0
`define MFPR_CODE_GPO       4'h1
`define MFPR_CODE_ALT       4'h2

// per terminal: which codes drive the pin (others leave it as input)
`define MFPR_OUT_MASK6      16'hFFFE
`define MFPR_OUT_MASK5      16'hFFFA
`define MFPR_OUT_MASK4      16'hFBFA
`define MFPR_OUT_MASK3      16'hFFFE
`define MFPR_OUT_MASK2      16'hFFFE
`define MFPR_OUT_MASK1      16'hFF0E
`define MFPR_OUT_MASK0      16'hFFFE

`endif

// ==== logic/mfpr_pkg.sv ====
// types shared by the multifunction pin routing block
// assumes mfpr_params.svh is on the include path
`include "mfpr_params.svh"

package mfpr_pkg;

   // internal functions that may be routed out to a terminal
   typedef struct packed {
      logic [15:0] irq;
      logic        clock_run;
      logic        serialized_interrupt;
      logic        pc_request;
      logic        video_port_status;
      logic        video_port_select0;
      logic        video_port_select1;
      logic        card_audio_pwm;
      logic        link_activity_led;
      logic        indicator_a1;
      logic        indicator_a2;
      logic        socket_indicator;
      logic        power_event_out;
      logic        ring_indicate_out;
      logic        test_observe_out;
      logic        pci_inta;
      logic        pci_intb;
      logic        pci_intc;
   } mfpr_func_t;

   // levels sensed on terminals configured as inputs
   typedef struct packed {
      logic [4:0] gen_input;
      logic       pc_grant;
      logic       lock_in;
   } mfpr_sense_t;

endpackage : mfpr_pkg

// ==== logic/mfpr_term_mux.sv ====
// one multifunction terminal: 16-way selector with registered pin drive
// assumes sel and src are on sys_clk; pin wire is resolved outside
`timescale 1ns/1ns
`include "mfpr_params.svh"

module mfpr_term_mux #(
   parameter logic [15:0] OUT_MASK = 16'hFFFF
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        global_reset_n,
   // selection
   input  wire logic [3:0]  sel,
   input  wire logic [15:0] src,
   // pin
   output logic             pin_out,
   output logic             pin_oe_n
);

   logic pin_out_nxt;
   logic pin_oe_n_nxt;

   always_comb begin
      pin_out_nxt  = src[sel];
      pin_oe_n_nxt = ~OUT_MASK[sel];
   end

   // inputs and reserved codes float so the board can drive the pin
   always_ff @(posedge sys_clk or negedge global_reset_n) begin
      if (!global_reset_n) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out  <= pin_out_nxt;
         pin_oe_n <= pin_oe_n_nxt;
      end
   end

   property p_mux_follow;
      @(posedge sys_clk) disable iff (!global_reset_n)
      $stable(sel) && $stable(src) |=> (pin_out == $past(src[sel])) && (pin_oe_n == ~OUT_MASK[$past(sel)]);
   endproperty
   a_mux_follow: assert property (p_mux_follow) else $error("terminal pin does not follow its selected source");

endmodule // mfpr_term_mux

// ==== logic/mfpr_top.sv ====
// multifunction pin routing: output data and routing registers over APB,
// seven terminal selectors, two-flop sensing of terminal inputs
// assumes an APB master on sys_clk and board logic resolving each pin
//
// Contract
// - an 8-bit output data register whose bits 4..0 set the levels for general outputs 4..0.
// - bits 7..5 of the output data register read zero and ignore writes.
// - the output data register resets to zero and is cleared only by the global reset.
// - the routing register resets to 0x00001000 and, of the two resets, only the global reset affects it.
// - the routing register can be loaded from a serial configuration ROM instead of the reset value.
// - routing bits 31..28 are read-only and read zero.
// - bits 27..24 route terminal six: reserved, clock run, then legacy interrupts 2..15.
// - bits 23..20 route terminal five among input4, output4, grant, interrupts, video, audio, LEDs, power event.
// - bits 19..16 route terminal four among input3, output3, lock, interrupts, video, audio, ring, LED, power event.
// - bits 15..12 route terminal three: reserved, serialized interrupt, then legacy interrupts 2..15.
// - bits 11..8 route terminal two among input2, output2, request, interrupts, video, audio, ring, test, power event.
// - bits 7..4 route terminal one among input1, output1, INTB, interrupts, audio, LEDs, power event.
// - bits 3..0 route terminal zero among input0, output0, INTA, interrupts, video, audio, LEDs, power event.
`timescale 1ns/1ns
`include "mfpr_params.svh"

module mfpr_top #(
   parameter int ADDR_W = 12
) (
   // clock and resets
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire logic                 global_reset_n,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // serial rom loader
   input  wire logic                 rom_load_valid,
   input  wire logic [31:0]          rom_load_data,
   // internal functions
   input  wire mfpr_pkg::mfpr_func_t func,
   output mfpr_pkg::mfpr_sense_t     sense,
   // terminals
   input  wire logic [6:0]           term_in,
   output logic [6:0]                term_out,
   output logic [6:0]                term_oe_n,
   // register view
   output logic [4:0]                gen_output,
   output logic [31:0]               routing
);

   localparam logic [ADDR_W-1:0] GPO_ADDR   = ADDR_W'({`MFPR_GPO_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] ROUTE_ADDR = ADDR_W'({`MFPR_ROUTE_IDX, 2'b00});
   if (ADDR_W < 10) begin : g_chk
      $error("mfpr_top: ADDR_W must be at least 10");
   end
   // bus decode
   logic        setup_ph, wr_acc, hit_gpo, hit_route, wr_gpo, wr_route;

   always_comb begin
      setup_ph  = psel && !penable;
      wr_acc    = psel && penable && pwrite;
      hit_gpo   = (paddr == GPO_ADDR);
      hit_route = (paddr == ROUTE_ADDR);
      wr_gpo    = wr_acc && hit_gpo && pstrb[0];
      wr_route  = wr_acc && hit_route;
   end

   // read data is prepared in setup so the access phase answers at once
   logic [31:0] prdata_r, prdata_nxt;
   logic        pslverr_r, pslverr_nxt;

   // configuration state
   logic [7:0]  gpo_r, gpo_nxt;
   logic [31:0] route_r, route_nxt;

   always_comb begin
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup_ph) begin
         pslverr_nxt = !(hit_gpo || hit_route);
         if (hit_gpo) begin
            prdata_nxt = {24'h00_0000, gpo_r & `MFPR_GPO_WMASK};
         end else if (hit_route) begin
            prdata_nxt = route_r & `MFPR_ROUTE_WMASK;
         end else begin
            prdata_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   always_comb begin
      pready  = psel && penable;
      prdata  = prdata_r;
      pslverr = pslverr_r && psel && penable;
   end

   always_comb begin
      gpo_nxt   = gpo_r;
      route_nxt = route_r;
      if (wr_gpo) begin
         gpo_nxt = pwdata[7:0] & `MFPR_GPO_WMASK;
      end
      if (wr_route) begin
         for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) begin
               route_nxt[8*i +: 8] = pwdata[8*i +: 8];
            end
         end
      end
      // rom image wins over a bus write
      if (rom_load_valid) begin
         route_nxt = rom_load_data;
      end
      route_nxt = route_nxt & `MFPR_ROUTE_WMASK;
   end

   // only the global reset clears these; bus reset leaves them
   always_ff @(posedge sys_clk or negedge global_reset_n) begin
      if (!global_reset_n) begin
         gpo_r   <= `MFPR_GPO_RST;
         route_r <= `MFPR_ROUTE_RST;
      end else begin
         gpo_r   <= gpo_nxt;
         route_r <= route_nxt;
      end
   end

   always_comb begin
      gen_output = gpo_r[4:0];
      routing    = route_r;
   end

   // select fields
   logic [3:0] sel6, sel5, sel4, sel3, sel2, sel1, sel0;

   always_comb begin
      sel6 = route_r[`MFPR_TERM6_LSB +: `MFPR_SEL_W];
      sel5 = route_r[`MFPR_TERM5_LSB +: `MFPR_SEL_W];
      sel4 = route_r[`MFPR_TERM4_LSB +: `MFPR_SEL_W];
      sel3 = route_r[`MFPR_TERM3_LSB +: `MFPR_SEL_W];
      sel2 = route_r[`MFPR_TERM2_LSB +: `MFPR_SEL_W];
      sel1 = route_r[`MFPR_TERM1_LSB +: `MFPR_SEL_W];
      sel0 = route_r[`MFPR_TERM0_LSB +: `MFPR_SEL_W];
   end

   // source tables, index is the select code; input codes carry zero
   logic [15:0] src6, src5, src4, src3, src2, src1, src0;

   always_comb begin
      src6 = {func.irq[15:2], func.clock_run, 1'b0};
      src5 = {func.irq[15], func.power_event_out, func.socket_indicator, func.indicator_a1,
              func.link_activity_led, func.irq[10], func.irq[9], func.card_audio_pwm,
              func.video_port_select1, func.video_port_status, func.irq[5:3], 1'b0, gpo_r[4], 1'b0};
      src4 = {func.irq[15], func.power_event_out, func.socket_indicator, func.ring_indicate_out,
              func.irq[11], 1'b0, func.irq[9], func.card_audio_pwm,
              func.video_port_select1, func.video_port_status, func.irq[5:3], 1'b0, gpo_r[3], 1'b0};
      src3 = {func.irq[15:2], func.serialized_interrupt, 1'b0};
      src2 = {func.irq[7], func.power_event_out, func.test_observe_out, func.ring_indicate_out,
              func.pci_intc, func.irq[10], func.irq[9], func.card_audio_pwm,
              func.video_port_select0, func.video_port_status, func.irq[5:3], func.pc_request, gpo_r[2], 1'b0};
      src1 = {func.irq[15], func.power_event_out, func.indicator_a2, func.indicator_a1,
              func.irq[11:9], func.card_audio_pwm, 4'h0, func.irq[3], func.pci_intb, gpo_r[1], 1'b0};
      src0 = {func.irq[15], func.power_event_out, func.indicator_a2, func.indicator_a1,
              func.irq[11:9], func.card_audio_pwm,
              func.video_port_select0, func.video_port_status, func.irq[5:3], func.pci_inta, gpo_r[0], 1'b0};
   end

   // output codes drive, input codes float
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK6)) u_term6 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel6), .src(src6),
      .pin_out(term_out[6]), .pin_oe_n(term_oe_n[6]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK5)) u_term5 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel5), .src(src5),
      .pin_out(term_out[5]), .pin_oe_n(term_oe_n[5]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK4)) u_term4 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel4), .src(src4),
      .pin_out(term_out[4]), .pin_oe_n(term_oe_n[4]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK3)) u_term3 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel3), .src(src3),
      .pin_out(term_out[3]), .pin_oe_n(term_oe_n[3]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK2)) u_term2 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel2), .src(src2),
      .pin_out(term_out[2]), .pin_oe_n(term_oe_n[2]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK1)) u_term1 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel1), .src(src1),
      .pin_out(term_out[1]), .pin_oe_n(term_oe_n[1]));
   mfpr_term_mux #(.OUT_MASK(`MFPR_OUT_MASK0)) u_term0 (
      .sys_clk(sys_clk), .global_reset_n(global_reset_n), .sel(sel0), .src(src0),
      .pin_out(term_out[0]), .pin_oe_n(term_oe_n[0]));

   // input sensing: pins are asynchronous, two flops before any use
   logic [6:0]            meta_r, sync_r;
   mfpr_pkg::mfpr_sense_t sense_r, sense_nxt;

   always_comb begin
      sense_nxt.gen_input[0] = (sel0 == `MFPR_CODE_GPI) && sync_r[0];
      sense_nxt.gen_input[1] = (sel1 == `MFPR_CODE_GPI) && sync_r[1];
      sense_nxt.gen_input[2] = (sel2 == `MFPR_CODE_GPI) && sync_r[2];
      sense_nxt.gen_input[3] = (sel4 == `MFPR_CODE_GPI) && sync_r[4];
      sense_nxt.gen_input[4] = (sel5 == `MFPR_CODE_GPI) && sync_r[5];
      // grant and lock idle high when not routed
      sense_nxt.pc_grant     = (sel5 == `MFPR_CODE_ALT) ? sync_r[5] : 1'b1;
      sense_nxt.lock_in      = (sel4 == `MFPR_CODE_ALT) ? sync_r[4] : 1'b1;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_r  <= 7'h00;
         sync_r  <= 7'h00;
         sense_r <= 7'h03;
      end else begin
         meta_r  <= term_in;
         sync_r  <= meta_r;
         sense_r <= sense_nxt;
      end
   end

   always_comb begin
      sense = sense_r;
   end

   // checks
   // write lands
   property p_gpo_write;
      @(posedge sys_clk) disable iff (!global_reset_n)
      wr_gpo |=> gen_output == $past(pwdata[4:0]);
   endproperty
   a_gpo_write: assert property (p_gpo_write) else $error("output data write not stored");
   property p_gpo_upper;
      @(posedge sys_clk) disable iff (!nrst || !global_reset_n)
      setup_ph && hit_gpo |=> prdata[31:5] == 27'h0 && pready && !pslverr;
   endproperty
   a_gpo_upper: assert property (p_gpo_upper) else $error("output data upper bits not zero");
   property p_gpo_rst;
      @(posedge sys_clk) $rose(global_reset_n) |-> gpo_r == 8'h00 && term_oe_n == 7'h7F;
   endproperty
   a_gpo_rst: assert property (p_gpo_rst) else $error("output data not cleared by global reset");
   property p_route_rst;
      @(posedge sys_clk) $rose(global_reset_n) |-> routing == 32'h0000_1000;
   endproperty
   a_route_rst: assert property (p_route_rst) else $error("routing reset value wrong");
   property p_route_keep;
      @(posedge sys_clk) disable iff (!global_reset_n)
      !nrst && !rom_load_valid |=> $stable(routing) && $stable(gen_output);
   endproperty
   a_route_keep: assert property (p_route_keep) else $error("bus reset disturbed configuration");
   property p_rom_load;
      @(posedge sys_clk) disable iff (!global_reset_n)
      rom_load_valid |=> routing == ($past(rom_load_data) & 32'h0FFF_FFFF);
   endproperty
   a_rom_load: assert property (p_rom_load) else $error("rom image not loaded");
   property p_route_top;
      @(posedge sys_clk) disable iff (!global_reset_n) routing[31:28] == 4'h0;
   endproperty
   a_route_top: assert property (p_route_top) else $error("routing top bits not zero");
   property p_t6_clock_run;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel6 == 4'h1) [*2] |-> term_out[6] == $past(func.clock_run) && !term_oe_n[6];
   endproperty
   a_t6_clock_run: assert property (p_t6_clock_run) else $error("terminal six clock run wrong");
   property p_t5_link;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel5 == 4'hB) [*2] |-> term_out[5] == $past(func.link_activity_led);
   endproperty
   a_t5_link: assert property (p_t5_link) else $error("terminal five link led wrong");
   property p_t4_rsvd;
      @(posedge sys_clk) disable iff (!global_reset_n) (sel4 == 4'hA) |=> term_oe_n[4];
   endproperty
   a_t4_rsvd: assert property (p_t4_rsvd) else $error("terminal four reserved code drives");
   property p_t3_irq;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel3 == 4'hF) [*2] |-> term_out[3] == $past(func.irq[15]);
   endproperty
   a_t3_irq: assert property (p_t3_irq) else $error("terminal three interrupt 15 wrong");
   property p_t2_test;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel2 == 4'hD) [*2] |-> term_out[2] == $past(func.test_observe_out);
   endproperty
   a_t2_test: assert property (p_t2_test) else $error("terminal two test output wrong");
   property p_t1_a2;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel1 == 4'hD) [*2] |-> term_out[1] == $past(func.indicator_a2);
   endproperty
   a_t1_a2: assert property (p_t1_a2) else $error("terminal one indicator a2 wrong");
   property p_t0_gpo;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel0 == 4'h1) [*2] |-> term_out[0] == $past(gpo_r[0]) && !term_oe_n[0];
   endproperty
   a_t0_gpo: assert property (p_t0_gpo) else $error("terminal zero not driven by output data");
   property p_t0_inta;
      @(posedge sys_clk) disable iff (!global_reset_n)
      (sel0 == 4'h2) [*2] |-> term_out[0] == $past(func.pci_inta);
   endproperty
   a_t0_inta: assert property (p_t0_inta) else $error("terminal zero INTA wrong");
   property p_t5_gpi;
      @(posedge sys_clk) disable iff (!global_reset_n) (sel5 == 4'h0) |=> term_oe_n[5];
   endproperty
   a_t5_gpi: assert property (p_t5_gpi) else $error("general input terminal driven");
   c_gpo_write: cover property (@(posedge sys_clk) wr_gpo);
   c_route_write: cover property (@(posedge sys_clk) wr_route && pstrb == 4'hF);
   c_rom_load: cover property (@(posedge sys_clk) rom_load_valid);
   c_unmapped: cover property (@(posedge sys_clk) pslverr);

endmodule // mfpr_top

// ==== tb/mfpr_board.sv ====
// board model on the seven multifunction terminals
// assumes the bench supplies the level that outside circuitry puts on a released pin
`timescale 1ns/1ns

module mfpr_board (
   // device side
   input  wire logic [6:0] term_out,
   input  wire logic [6:0] term_oe_n,
   // board side
   input  wire logic [6:0] ext_level,
   output logic [6:0]      term_in
);
   // a driven pin reads back the device level; a released pin reads the board level
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         term_in[i] = term_oe_n[i] ? ext_level[i] : term_out[i];
      end
   end
endmodule // mfpr_board

// ==== tb/tb_mfpr_top.sv ====
// self-checking bench for the multifunction pin routing block
// assumes the board model on the terminals and an APB master on sys_clk
`timescale 1ns/1ns

module tb_mfpr_top;
   logic                  sys_clk = 0, nrst = 0, global_reset_n = 0;
   logic                  psel = 0, penable = 0, pwrite = 0, rom_load_valid = 0;
   logic [11:0]           paddr = 0;
   logic [31:0]           pwdata = 0, rom_load_data = 0, prdata, routing, rd, w;
   logic [3:0]            pstrb = 0, cv;
   logic                  pready, pslverr, er;
   mfpr_pkg::mfpr_func_t  func = '0;
   mfpr_pkg::mfpr_sense_t sense;
   logic [6:0]            term_in, term_out, term_oe_n, ext_level = 0;
   logic [4:0]            gen_output, g;
   logic [63:0]           rnd;
   int                    err_count = 0, tests_run = 0, cyc = 0, seed = 43055;

   always #5 sys_clk = ~sys_clk;

   mfpr_top mfpr_top_i (.sys_clk, .nrst, .global_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .rom_load_valid, .rom_load_data, .func, .sense, .term_in,
      .term_out, .term_oe_n, .gen_output, .routing);
   mfpr_board mfpr_board_i (.term_out, .term_oe_n, .ext_level, .term_in);

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one transfer; entered just after a rising edge, leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // expected {oe_n, out} of terminal t for select code c
   function automatic logic [1:0] exp_pin(int t, logic [3:0] c, mfpr_pkg::mfpr_func_t f, logic [4:0] gd);
      logic v;
      logic d;
      d = 1'b1;
      v = f.irq[c];
      if (t == 6 || t == 3) begin
         if (c == 4'h0) d = 1'b0;
         else if (c == 4'h1) v = (t == 6) ? f.clock_run : f.serialized_interrupt;
      end else begin
         case (c)
            4'h0: d = 1'b0;
            4'h1: v = gd[(t > 3) ? t - 1 : t];
            4'h2: if (t == 0) v = f.pci_inta; else if (t == 1) v = f.pci_intb;
               else if (t == 2) v = f.pc_request; else d = 1'b0;
            4'h4, 4'h5, 4'h6, 4'h7: if (t == 1) d = 1'b0; else if (c == 4'h6) v = f.video_port_status;
               else if (c == 4'h7) v = (t == 2 || t == 0) ? f.video_port_select0 : f.video_port_select1;
            4'h8: v = f.card_audio_pwm;
            4'hA: if (t == 4) d = 1'b0;
            4'hB: if (t == 5) v = f.link_activity_led; else if (t == 2) v = f.pci_intc;
            4'hC: v = (t == 2 || t == 4) ? f.ring_indicate_out : f.indicator_a1;
            4'hD: v = (t == 2) ? f.test_observe_out : (t < 2) ? f.indicator_a2 : f.socket_indicator;
            4'hE: v = f.power_event_out;
            4'hF: if (t == 2) v = f.irq[7];
            default: ;
         endcase
      end
      return d ? {1'b0, v} : 2'b10;
   endfunction

   // a hang ends the run through the closing report
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         stop_test;
      end
   end

   initial begin
      rnd = {$random(seed), $random(seed)};
      func <= rnd[$bits(func)-1:0];
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      global_reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      apb(1'b0, 12'h22C, 32'h0, 4'hF);
      chk("gpo reset", 32'h0000_0000, rd);
      apb(1'b0, 12'h230, 32'h0, 4'hF);
      chk("route reset", 32'h0000_1000, rd);
      chk("reset pins", {18'h0, 7'h77, 3'h0, func.serialized_interrupt, 3'h0}, {18'h0, term_oe_n, term_out});
      apb(1'b1, 12'h22C, 32'hFFFF_FFFF, 4'hF);
      apb(1'b1, 12'h22C, 32'h0000_0000, 4'hE);
      apb(1'b0, 12'h22C, 32'h0, 4'hF);
      chk("gpo read", 32'h0000_001F, rd);
      chk("gpo level", 32'h0000_001F, {27'h0, gen_output});
      // power-on programming of the routing; the sweep below rewrites it on purpose
      apb(1'b1, 12'h230, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, 12'h230, 32'h0, 4'hF);
      chk("route read", 32'h0FFF_FFFF, rd);
      apb(1'b0, 12'h100, 32'h0, 4'hF);
      chk("unmapped", 32'h0000_0001, {31'h0, er});
      chk("unmapped data", 32'h0000_0000, rd);
      // the bus reset must leave both registers alone
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      chk("gpo after bus reset", 32'h0000_001F, {27'h0, gen_output});
      chk("route after bus reset", 32'h0FFF_FFFF, routing);
      w = $random(seed);
      rom_load_valid <= 1'b1;
      rom_load_data <= w;
      @(posedge sys_clk);
      rom_load_valid <= 1'b0;
      @(posedge sys_clk);
      chk("rom load", w & 32'h0FFF_FFFF, routing);
      // every code on every terminal at once, random function levels and board levels
      for (int c = 0; c < 16; c++) begin
         cv = c[3:0];
         rnd = {$random(seed), $random(seed)};
         g = rnd[63:59];
         func <= rnd[$bits(func)-1:0];
         ext_level <= rnd[56:50];
         apb(1'b1, 12'h22C, {27'h0, g}, 4'hF);
         apb(1'b1, 12'h230, {4'h0, {7{cv}}}, 4'hF);
         repeat (6) @(posedge sys_clk);
         chk("route field", {4'h0, {7{cv}}}, routing);
         for (int t = 0; t < 7; t++) begin
            chk("pin", {30'h0, exp_pin(t, cv, func, g)}, {30'h0, term_oe_n[t], term_out[t]});
         end
         chk("sense", {25'h0, (cv == 4'h0) ? {ext_level[5:4], ext_level[2:0]} : 5'h00,
            (cv == 4'h2) ? ext_level[5:4] : 2'b11}, {25'h0, sense});
      end
      global_reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      global_reset_n <= 1'b1;
      @(posedge sys_clk);
      chk("gpo global reset", 32'h0000_0000, {27'h0, gen_output});
      chk("route global reset", 32'h0000_1000, routing);
      stop_test;
   end
endmodule // tb_mfpr_top
